// >>> rtl/ocdja_consts.svh
`ifndef OCDJA_CONSTS_SVH
`define OCDJA_CONSTS_SVH

// Instruction register
`define OCDJA_IR_W 4
`define OCDJA_IR_RESET 4'h1
`define OCDJA_IR_CAPTURE 4'h1
`define OCDJA_IR_BYPASS 4'hF
// Debug access opcodes
`define OCDJA_INSTR_A 4'h8
`define OCDJA_INSTR_B 4'h9
`define OCDJA_INSTR_C 4'hA
`define OCDJA_INSTR_D 4'hB
// Mailbox
`define OCDJA_MBOX_W 8
`define OCDJA_MBOX_RESET 8'h00
`define OCDJA_DIRTY_BIT 7

`endif

// >>> rtl/ocdja_pkg.sv
`default_nettype none
`include "ocdja_consts.svh"

package ocdja_pkg;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
    TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } ocdja_tap_t;

  typedef struct packed {
    logic hit;
    logic rd;
    logic wr;
    logic [`OCDJA_MBOX_W-1:0] wdata;
  } ocdja_cpu_req_t;

  typedef struct packed {
    logic [2:0] tck_sync;
    logic [1:0] tms_sync;
    logic [1:0] tdi_sync;
    ocdja_tap_t tap;
    logic [`OCDJA_IR_W-1:0] ir;
    logic [`OCDJA_IR_W-1:0] ir_shift;
    logic [`OCDJA_MBOX_W-1:0] dr_shift;
    logic tdo;
    logic tdo_drive;
    logic [`OCDJA_MBOX_W-1:0] mbox;
    logic dirty;
    logic access_en;
    logic [`OCDJA_MBOX_W-1:0] host_byte;
    logic host_valid;
    logic [`OCDJA_MBOX_W-1:0] rdata;
    logic erase_seen;
  } ocdja_state_t;

endpackage
`default_nettype wire

// >>> rtl/ocdja_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ocdja_consts.svh"

module ocdja_top (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  output logic tdo_o,
  output logic tdo_oe_n_o,
  input wire logic test_port_enable_fuse_i,
  input wire logic test_port_disable_bit_i,
  input wire logic debug_enable_fuse_i,
  input wire logic lock_bit_one_i,
  input wire logic lock_bit_two_i,
  input wire logic chip_erase_done_i,
  input wire ocdja_pkg::ocdja_cpu_req_t cpu_req_i,
  output logic [7:0] cpu_rdata_o,
  output logic std_rd_o,
  output logic std_wr_o,
  input wire logic [7:0] std_rdata_i,
  output logic [7:0] host_byte_o,
  output logic host_byte_valid_o,
  output logic tap_enabled_o,
  output logic debug_enabled_o,
  output logic [1:0] debug_instr_o,
  output logic debug_instr_active_o,
  output logic prog_path_enable_o,
  output logic debug_fuse_prog_ok_o
);

  // ****************************************
  // Qualifiers
  // ****************************************
  ocdja_pkg::ocdja_state_t s_reg;
  ocdja_pkg::ocdja_state_t s_next;
  logic tap_en;
  logic dbg_en;
  logic any_lock;
  logic route_mbox;
  logic tck_rise;
  logic tck_fall;
  logic tms;
  logic tdi;
  logic priv;
  logic host_set;

  assign tap_en = test_port_enable_fuse_i & ~test_port_disable_bit_i;
  assign any_lock = lock_bit_one_i | lock_bit_two_i;
  assign dbg_en = tap_en & debug_enable_fuse_i & ~any_lock;
  // Lock bits cut the mailbox route in the same cycle
  assign route_mbox = debug_enable_fuse_i & dbg_en & s_reg.access_en;
  assign tck_rise = s_reg.tck_sync[1] & ~s_reg.tck_sync[2];
  assign tck_fall = ~s_reg.tck_sync[1] & s_reg.tck_sync[2];
  assign tms = s_reg.tms_sync[1];
  assign tdi = s_reg.tdi_sync[1];
  assign priv = dbg_en && (s_reg.ir[3:2] == 2'(`OCDJA_INSTR_A >> 2));
  // Debugger byte update outranks a CPU read clear
  assign host_set = tck_rise & (s_reg.tap == ocdja_pkg::TAP_UPD_DR) & priv
    & (s_reg.ir == `OCDJA_INSTR_C);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_next = s_reg;
    s_next.tck_sync = {s_reg.tck_sync[1:0], tck_i};
    s_next.tms_sync = {s_reg.tms_sync[0], tms_i};
    s_next.tdi_sync = {s_reg.tdi_sync[0], tdi_i};
    if (chip_erase_done_i) begin
      s_next.erase_seen = 1'b1;
    end
    if (!tap_en) begin
      s_next.tap = ocdja_pkg::TAP_RESET;
      s_next.ir = `OCDJA_IR_RESET;
      s_next.tdo_drive = 1'b0;
    end else if (tck_rise) begin
      case (s_reg.tap)
        ocdja_pkg::TAP_RESET: s_next.tap = tms ? ocdja_pkg::TAP_RESET : ocdja_pkg::TAP_IDLE;
        ocdja_pkg::TAP_IDLE: s_next.tap = tms ? ocdja_pkg::TAP_SEL_DR : ocdja_pkg::TAP_IDLE;
        ocdja_pkg::TAP_SEL_DR: s_next.tap = tms ? ocdja_pkg::TAP_SEL_IR : ocdja_pkg::TAP_CAP_DR;
        ocdja_pkg::TAP_CAP_DR:
          s_next.tap = tms ? ocdja_pkg::TAP_EXIT1_DR : ocdja_pkg::TAP_SHIFT_DR;
        ocdja_pkg::TAP_SHIFT_DR:
          s_next.tap = tms ? ocdja_pkg::TAP_EXIT1_DR : ocdja_pkg::TAP_SHIFT_DR;
        ocdja_pkg::TAP_EXIT1_DR:
          s_next.tap = tms ? ocdja_pkg::TAP_UPD_DR : ocdja_pkg::TAP_PAUSE_DR;
        ocdja_pkg::TAP_PAUSE_DR:
          s_next.tap = tms ? ocdja_pkg::TAP_EXIT2_DR : ocdja_pkg::TAP_PAUSE_DR;
        ocdja_pkg::TAP_EXIT2_DR:
          s_next.tap = tms ? ocdja_pkg::TAP_UPD_DR : ocdja_pkg::TAP_SHIFT_DR;
        ocdja_pkg::TAP_UPD_DR: s_next.tap = tms ? ocdja_pkg::TAP_SEL_DR : ocdja_pkg::TAP_IDLE;
        ocdja_pkg::TAP_SEL_IR: s_next.tap = tms ? ocdja_pkg::TAP_RESET : ocdja_pkg::TAP_CAP_IR;
        ocdja_pkg::TAP_CAP_IR:
          s_next.tap = tms ? ocdja_pkg::TAP_EXIT1_IR : ocdja_pkg::TAP_SHIFT_IR;
        ocdja_pkg::TAP_SHIFT_IR:
          s_next.tap = tms ? ocdja_pkg::TAP_EXIT1_IR : ocdja_pkg::TAP_SHIFT_IR;
        ocdja_pkg::TAP_EXIT1_IR:
          s_next.tap = tms ? ocdja_pkg::TAP_UPD_IR : ocdja_pkg::TAP_PAUSE_IR;
        ocdja_pkg::TAP_PAUSE_IR:
          s_next.tap = tms ? ocdja_pkg::TAP_EXIT2_IR : ocdja_pkg::TAP_PAUSE_IR;
        ocdja_pkg::TAP_EXIT2_IR:
          s_next.tap = tms ? ocdja_pkg::TAP_UPD_IR : ocdja_pkg::TAP_SHIFT_IR;
        ocdja_pkg::TAP_UPD_IR: s_next.tap = tms ? ocdja_pkg::TAP_SEL_DR : ocdja_pkg::TAP_IDLE;
        default: s_next.tap = ocdja_pkg::TAP_RESET;
      endcase
      case (s_reg.tap)
        ocdja_pkg::TAP_RESET: begin
          s_next.ir = `OCDJA_IR_RESET;
        end
        ocdja_pkg::TAP_CAP_IR: begin
          s_next.ir_shift = `OCDJA_IR_CAPTURE;
        end
        ocdja_pkg::TAP_SHIFT_IR: begin
          s_next.ir_shift = {tdi, s_reg.ir_shift[`OCDJA_IR_W-1:1]};
        end
        ocdja_pkg::TAP_UPD_IR: begin
          s_next.ir = s_reg.ir_shift;
        end
        ocdja_pkg::TAP_CAP_DR: begin
          if (priv && s_reg.ir == `OCDJA_INSTR_A) begin
            s_next.dr_shift = s_reg.mbox;
          end else if (priv && s_reg.ir == `OCDJA_INSTR_B) begin
            s_next.dr_shift = {s_reg.dirty, 6'h00, s_reg.access_en};
          end else begin
            s_next.dr_shift = `OCDJA_MBOX_RESET;
          end
        end
        ocdja_pkg::TAP_SHIFT_DR: begin
          if (priv) begin
            s_next.dr_shift = {tdi, s_reg.dr_shift[`OCDJA_MBOX_W-1:1]};
          end else begin
            s_next.dr_shift = {7'h00, tdi};
          end
        end
        ocdja_pkg::TAP_UPD_DR: begin
          if (priv && s_reg.ir == `OCDJA_INSTR_A) begin
            s_next.dirty = 1'b0;
          end
          if (priv && s_reg.ir == `OCDJA_INSTR_B) begin
            s_next.access_en = s_reg.dr_shift[0];
          end
          if (priv && s_reg.ir == `OCDJA_INSTR_C) begin
            s_next.host_byte = s_reg.dr_shift;
            s_next.host_valid = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end else if (tck_fall) begin
      s_next.tdo_drive = (s_reg.tap == ocdja_pkg::TAP_SHIFT_DR)
        || (s_reg.tap == ocdja_pkg::TAP_SHIFT_IR);
      s_next.tdo = (s_reg.tap == ocdja_pkg::TAP_SHIFT_IR) ? s_reg.ir_shift[0]
        : s_reg.dr_shift[0];
    end
    if (!dbg_en) begin
      s_next.access_en = 1'b0;
    end
    // CPU side of the mailbox
    if (cpu_req_i.hit && route_mbox && cpu_req_i.wr) begin
      s_next.mbox = cpu_req_i.wdata;
      s_next.dirty = 1'b1;
    end
    if (cpu_req_i.hit && cpu_req_i.rd) begin
      if (route_mbox) begin
        s_next.rdata = {s_reg.dirty, s_reg.mbox[`OCDJA_DIRTY_BIT-1:0]};
        if (!host_set) begin
          s_next.host_valid = 1'b0;
        end
      end else begin
        s_next.rdata = std_rdata_i;
      end
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_reg <= '0;
      s_reg.tap <= ocdja_pkg::TAP_RESET;
      s_reg.ir <= `OCDJA_IR_RESET;
      s_reg.mbox <= `OCDJA_MBOX_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign tdo_o = s_reg.tdo;
  assign tdo_oe_n_o = ~s_reg.tdo_drive;
  assign cpu_rdata_o = s_reg.rdata;
  assign std_rd_o = cpu_req_i.hit & cpu_req_i.rd & ~route_mbox;
  assign std_wr_o = cpu_req_i.hit & cpu_req_i.wr & ~route_mbox;
  assign host_byte_o = s_reg.host_byte;
  assign host_byte_valid_o = s_reg.host_valid;
  assign tap_enabled_o = tap_en;
  assign debug_enabled_o = dbg_en;
  assign debug_instr_o = s_reg.ir[1:0];
  assign debug_instr_active_o = priv;
  assign prog_path_enable_o = tap_en;
  assign debug_fuse_prog_ok_o = ~any_lock | s_reg.erase_seen;

endmodule
`default_nettype wire

// >>> verification/ocdja_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ocdja_top_asserts (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire ocdja_pkg::ocdja_cpu_req_t cpu_req_i,
  input wire logic [7:0] cpu_rdata_o,
  input wire logic std_rd_o,
  input wire logic std_wr_o,
  input wire logic [7:0] std_rdata_i,
  input wire logic test_port_enable_fuse_i,
  input wire logic test_port_disable_bit_i,
  input wire logic debug_enable_fuse_i,
  input wire logic lock_bit_one_i,
  input wire logic lock_bit_two_i,
  input wire logic chip_erase_done_i,
  input wire logic tdo_oe_n_o,
  input wire logic tap_enabled_o,
  input wire logic debug_enabled_o,
  input wire logic debug_instr_active_o,
  input wire logic debug_fuse_prog_ok_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);
  // Routed mailbox accesses
  sequence mb_wr;
    cpu_req_i.hit && cpu_req_i.wr && !std_wr_o;
  endsequence
  sequence mb_rd;
    cpu_req_i.hit && cpu_req_i.rd && !std_rd_o;
  endsequence
  tap_gate_a: assert property (
    tap_enabled_o == (test_port_enable_fuse_i & ~test_port_disable_bit_i)) else $error("tap");
  dbg_gate_a: assert property (
    debug_enabled_o == (tap_enabled_o & debug_enable_fuse_i & ~(lock_bit_one_i | lock_bit_two_i)))
    else $error("debug gate");
  instr_gate_a: assert property (debug_instr_active_o |-> debug_enabled_o)
    else $error("instr gate");
  mbox_read_a: assert property (
    mb_wr ##1 mb_rd |=> cpu_rdata_o == {1'b1, $past(cpu_req_i.wdata[6:0], 2)})
    else $error("mailbox read");
  std_read_a: assert property (
    cpu_req_i.hit && cpu_req_i.rd && std_rd_o |=> cpu_rdata_o == $past(std_rdata_i))
    else $error("std read");
  std_write_a: assert property (
    cpu_req_i.hit && cpu_req_i.wr && !debug_enabled_o |-> std_wr_o) else $error("std write");
  erase_ok_a: assert property (chip_erase_done_i |=> debug_fuse_prog_ok_o)
    else $error("erase permit");
  oe_off_a: assert property (!tap_enabled_o [*3] |-> tdo_oe_n_o)
    else $error("tdo driven");
endmodule
bind ocdja_top ocdja_top_asserts u_chk (.*);
`default_nettype wire

// >>> verification/ocdja_jtag_host.sv
`timescale 1ns/1ps
`default_nettype none
module ocdja_jtag_host (
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  input wire logic tdo_i
);
  initial {tck_o, tms_o, tdi_o} = 3'h2;
  // TCK idles low; TDO taken just before the rise
  task automatic step(input logic m, input logic d, output logic q);
    {tms_o, tdi_o} = {m, d};
    #50 q = tdo_i;
    tck_o = 1'b1;
    #30 tck_o = 1'b0;
  endtask
  task automatic walk(input int n, input logic [7:0] m);
    logic q;
    for (int i = 0; i < n; i++) step(m[i], 1'b0, q);
  endtask
  // From idle: n bits LSB first, then back to idle
  task automatic scan(input logic ir, input int n, input logic [7:0] di, output logic [7:0] dq);
    logic q;
    dq = 8'h00;
    walk(ir ? 4 : 3, ir ? 8'h03 : 8'h01);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, di[i], q);
      dq[i] = q;
    end
    walk(2, 8'h01);
  endtask
endmodule
`default_nettype wire

// >>> verification/onchip_debug_jtag_access_tb.sv
`timescale 1ns/1ps
`default_nettype none
module onchip_debug_jtag_access_tb;
  logic ref_clk_i, resetn_i, tck_i, tms_i, tdi_i, tdo_o, tdo_oe_n_o, tdo_w, std_rd_o, std_wr_o;
  logic test_port_enable_fuse_i, test_port_disable_bit_i, debug_enable_fuse_i, lock_bit_one_i;
  logic lock_bit_two_i, chip_erase_done_i, host_byte_valid_o, tap_enabled_o, debug_enabled_o;
  logic debug_instr_active_o, prog_path_enable_o, debug_fuse_prog_ok_o;
  logic [1:0] debug_instr_o;
  logic [7:0] cpu_rdata_o, std_rdata_i, host_byte_o, d1, d2, q;
  ocdja_pkg::ocdja_cpu_req_t cpu_req_i;
  int seed = 81;
  int mismatches = 0;
  int checked = 0;
  ocdja_top DUT (.*);
  ocdja_jtag_host host (.tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i), .tdo_i(tdo_w));
  // Released TDO shows the inverse of its last value
  assign tdo_w = tdo_oe_n_o ? ~tdo_o : tdo_o;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] rd_exp(input logic dirty, input logic [7:0] d);
    return {dirty, d[6:0]};
  endfunction
  task automatic cpu(input logic [2:0] op, input logic [7:0] d);
    @(negedge ref_clk_i) cpu_req_i = {op, d};
  endtask
  task automatic give_verdict();
    if (mismatches == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    #200000;
    mismatches++;
    give_verdict();
  end
  initial begin
    {resetn_i, chip_erase_done_i, lock_bit_one_i, lock_bit_two_i, test_port_disable_bit_i} = '0;
    {test_port_enable_fuse_i, debug_enable_fuse_i} = 2'h3;
    cpu_req_i = '0;
    std_rdata_i = 8'($random(seed));
    d1 = 8'($random(seed));
    d2 = 8'($random(seed));
    repeat (6) @(negedge ref_clk_i);
    resetn_i = 1'b1;
    chk(cpu_rdata_o, 8'h00);
    cpu(3'h5, 8'h55);
    #1 chk({7'h0, std_wr_o}, 8'h01);
    cpu(3'h6, 8'h00);
    #1 chk({7'h0, std_rd_o}, 8'h01);
    cpu(3'h0, 8'h00);
    chk(cpu_rdata_o, std_rdata_i);
    host.walk(6, 8'h1f);
    for (int i = 8; i < 12; i++) begin
      host.scan(1'b1, 4, 8'(i), q);
      chk({q[3:0], 1'b0, debug_instr_active_o, debug_instr_o}, {4'h1, 2'h1, 2'(i)});
    end
    host.scan(1'b1, 4, 8'h09, q);
    host.scan(1'b0, 8, 8'h01, q);
    chk(q, 8'h00);
    cpu(3'h5, d1);
    #1 chk({6'h0, std_wr_o, std_rd_o}, 8'h00);
    cpu(3'h5, d2);
    cpu(3'h6, 8'h00);
    cpu(3'h0, 8'h00);
    chk(cpu_rdata_o, rd_exp(1'b1, d2));
    host.scan(1'b1, 4, 8'h08, q);
    host.scan(1'b0, 8, 8'h00, q);
    chk(q, d2);
    cpu(3'h6, 8'h00);
    cpu(3'h0, 8'h00);
    chk(cpu_rdata_o, rd_exp(1'b0, d2));
    host.scan(1'b1, 4, 8'h0a, q);
    host.scan(1'b0, 8, d1, q);
    chk(host_byte_o, d1);
    chk({7'h0, host_byte_valid_o}, 8'h01);
    cpu(3'h6, 8'h00);
    cpu(3'h0, 8'h00);
    chk({7'h0, host_byte_valid_o}, 8'h00);
    chk(cpu_rdata_o, rd_exp(1'b0, d2));
    lock_bit_two_i = 1'b1;
    cpu(3'h5, d1);
    #1 chk({5'h0, debug_fuse_prog_ok_o, debug_enabled_o, std_wr_o}, 8'h01);
    cpu(3'h0, 8'h00);
    host.scan(1'b0, 8, d2, q);
    chk(q, {d2[6:0], 1'b0});
    chk(host_byte_o, d1);
    cpu(3'h0, 8'h00);
    chip_erase_done_i = 1'b1;
    cpu(3'h0, 8'h00);
    chip_erase_done_i = 1'b0;
    #1 chk({7'h0, debug_fuse_prog_ok_o}, 8'h01);
    test_port_disable_bit_i = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    chk({5'h0, prog_path_enable_o, tap_enabled_o, tdo_oe_n_o}, 8'h01);
    give_verdict();
  end
endmodule
`default_nettype wire
